// ### include/hiccup_sync_pkg.sv
// constants, register map and state encoding for the light-load / hiccup / sync supervisor
package hiccup_sync_pkg;
  // clock and timing
  localparam int CLK_MHZ = 40;
  localparam int TCL_ON_US = 5000;
  localparam int TCL_OFF_US = 122000;
  localparam int TSS_RAMP_US = 1000;
  localparam int CL_ON_CYC = TCL_ON_US * CLK_MHZ;
  localparam int CL_OFF_CYC = TCL_OFF_US * CLK_MHZ;
  localparam int SS_RAMP_CYC = TSS_RAMP_US * CLK_MHZ;
  localparam int OSC_PERIOD_CYC = 216;
  localparam int DCM_QUAL = 2;

  localparam int APB_AW = 8;
  localparam int CNT_W = 24;
  localparam int OSC_W = 16;

  // register byte offsets
  localparam logic [APB_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [APB_AW-1:0] OSC_OFS = 8'h04;
  localparam logic [APB_AW-1:0] RAMP_OFS = 8'h08;
  localparam logic [APB_AW-1:0] CLON_OFS = 8'h0C;
  localparam logic [APB_AW-1:0] OFF_OFS = 8'h10;
  localparam logic [APB_AW-1:0] STAT_OFS = 8'h14;

  // control fields and reset value
  localparam int CTRL_LEADER_BIT = 0;
  localparam int CTRL_LATCH_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;

  typedef enum logic [2:0] {
    SS_LOW = 3'b000,
    SS_RAMP = 3'b001,
    SS_RUN = 3'b010,
    SS_CLTIME = 3'b011,
    SS_HICCUP = 3'b100,
    SS_LATCH = 3'b101
  } ss_state_t;
endpackage

// ### rtl/light_load_hiccup_sync_control.sv
// light-load mode, current-limit hiccup / latch-off and phase sync supervisor
`timescale 1ns/1ps

module light_load_hiccup_sync_control
  import hiccup_sync_pkg::*;
#(
  parameter int OSC_PERIOD = OSC_PERIOD_CYC,
  parameter int RAMP_CYCLES = SS_RAMP_CYC,
  parameter int CL_ON_CYCLES = CL_ON_CYC,
  parameter int OFF_CYCLES = CL_OFF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cs_below_llt,
  input wire logic llt_tied_ref,
  input wire logic llt_grounded,
  input wire logic cs_at_limit,
  input wire logic pwm_trip,
  input wire logic pwm_fall,
  input wire logic uvlo,
  input wire logic ss_forced_low,
  input wire logic sync_in,
  output logic sr_drive_e,
  output logic sr_drive_f,
  output logic dcm_mode,
  output logic hyst_src_en,
  output logic cs_pulldown_en,
  output logic cycle_limit,
  output logic switching_en,
  output logic out_phase,
  output logic sync_out,
  output logic sync_oe
);

  logic [1:0] ctrl;
  logic [OSC_W-1:0] osc_period;
  logic [CNT_W-1:0] ramp_cfg;
  logic [CNT_W-1:0] clon_cfg;
  logic [CNT_W-1:0] off_cfg;
  logic leader;
  logic latch_en;
  logic mapped;
  logic [31:0] rd_mux;
  logic [OSC_W-1:0] osc_cnt;
  logic osc_tick;
  logic osc_start;
  logic sync_prev;
  logic sync_fall;
  logic sync_seen;
  logic cl_seen;
  ss_state_t state;
  ss_state_t next_state;
  logic [CNT_W-1:0] ss_cnt;
  logic ss_hold;
  logic run_ok;
  logic [1:0] qual;

  assign leader = ctrl[CTRL_LEADER_BIT];
  assign latch_en = ctrl[CTRL_LATCH_BIT];

  // apb slave: zero wait states, read data captured in the setup cycle
  assign pready = 1'b1;
  assign mapped = (paddr == CTRL_OFS) || (paddr == OSC_OFS) || (paddr == RAMP_OFS) ||
                  (paddr == CLON_OFS) || (paddr == OFF_OFS) || (paddr == STAT_OFS);

  always_comb begin
    unique case (paddr)
      CTRL_OFS: rd_mux = {30'h0, ctrl};
      OSC_OFS: rd_mux = {16'h0, osc_period};
      RAMP_OFS: rd_mux = {8'h0, ramp_cfg};
      CLON_OFS: rd_mux = {8'h0, clon_cfg};
      OFF_OFS: rd_mux = {8'h0, off_cfg};
      STAT_OFS: rd_mux = {24'h0, sync_seen, switching_en, cycle_limit, dcm_mode,
                          out_phase, state};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0 : rd_mux;
      pslverr <= !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      osc_period <= OSC_W'(OSC_PERIOD);
      ramp_cfg <= CNT_W'(RAMP_CYCLES);
      clon_cfg <= CNT_W'(CL_ON_CYCLES);
      off_cfg <= CNT_W'(OFF_CYCLES);
    end else if (psel && penable && pwrite) begin
      unique case (paddr)
        CTRL_OFS: ctrl <= pwdata[1:0];
        OSC_OFS: osc_period <= pwdata[OSC_W-1:0];
        RAMP_OFS: ramp_cfg <= pwdata[CNT_W-1:0];
        CLON_OFS: clon_cfg <= pwdata[CNT_W-1:0];
        OFF_OFS: off_cfg <= pwdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // oscillator at twice the output rate; a follower restarts it on each sync falling edge
  assign sync_fall = !leader && sync_prev && !sync_in;
  assign osc_tick = (osc_cnt >= osc_period - 16'h0001);
  assign osc_start = osc_tick || sync_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_prev <= 1'b0;
    end else begin
      sync_prev <= sync_in;
    end
  end

  // without pulses the counter simply free-runs at the programmed period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt <= 16'h0000;
    end else if (osc_start) begin
      osc_cnt <= 16'h0000;
    end else begin
      osc_cnt <= osc_cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_seen <= 1'b0;
    end else if (sync_fall) begin
      sync_seen <= 1'b1;
    end else if (uvlo) begin
      sync_seen <= 1'b0;
    end
  end

  // each output half-cycle is one oscillator period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_phase <= 1'b0;
    end else if (osc_start) begin
      out_phase <= !out_phase;
    end
  end

  // leader sync: oscillator rate, high for the first half of each period once the soft-start is out of SS_LOW
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out <= 1'b0;
      sync_oe <= 1'b0;
    end else begin
      sync_oe <= leader;
      sync_out <= leader && (state != SS_LOW) && (osc_cnt < (osc_period >> 1));
    end
  end

  // limit seen somewhere in the current oscillator cycle; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cl_seen <= 1'b0;
    end else if (cs_at_limit) begin
      cl_seen <= 1'b1;
    end else if (osc_start) begin
      cl_seen <= 1'b0;
    end
  end

  // soft-start node model: counters stand in for the capacitor threshold crossings
  assign ss_hold = uvlo || ss_forced_low;

  always_comb begin
    next_state = state;
    if (ss_hold) begin
      next_state = SS_LOW;
    end else begin
      unique case (state)
        SS_LOW: next_state = SS_RAMP;
        SS_RAMP: begin
          // overcurrent here only limits per cycle; timing starts at the limit threshold
          if (ss_cnt >= ramp_cfg - 24'h000001) begin
            if (cs_at_limit || cl_seen) begin
              next_state = latch_en ? SS_LATCH : SS_CLTIME;
            end else begin
              next_state = SS_RUN;
            end
          end
        end
        SS_RUN: begin
          if (cs_at_limit) begin
            next_state = latch_en ? SS_LATCH : SS_CLTIME;
          end
        end
        SS_CLTIME: begin
          if (ss_cnt >= clon_cfg - 24'h000001) begin
            next_state = SS_HICCUP;
          end else if (osc_start && !cl_seen && !cs_at_limit) begin
            next_state = SS_RUN;
          end
        end
        SS_HICCUP: begin
          if (ss_cnt >= off_cfg - 24'h000001) begin
            next_state = SS_LOW;
          end
        end
        SS_LATCH: next_state = SS_LATCH;
        default: next_state = SS_LOW;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SS_LOW;
      ss_cnt <= 24'h000000;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        ss_cnt <= 24'h000000;
      end else begin
        ss_cnt <= ss_cnt + 24'h000001;
      end
    end
  end

  // light-load qualification; the comparator flag already encodes the fractional threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcm_mode <= 1'b0;
      qual <= 2'h0;
    end else if (llt_tied_ref) begin
      dcm_mode <= 1'b1;
      qual <= 2'h0;
    end else if (llt_grounded) begin
      dcm_mode <= 1'b0;
      qual <= 2'h0;
    end else if (pwm_fall) begin
      if (cs_below_llt != dcm_mode) begin
        if (qual == 2'(DCM_QUAL - 1)) begin
          dcm_mode <= cs_below_llt;
          qual <= 2'h0;
        end else begin
          qual <= qual + 2'h1;
        end
      end else begin
        qual <= 2'h0;
      end
    end
  end

  // the external divider sets the base level; the source only adds the hysteresis step
  assign hyst_src_en = dcm_mode;

  assign run_ok = ((state == SS_RAMP) || (state == SS_RUN) || (state == SS_CLTIME)) &&
                  (leader || sync_seen);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switching_en <= 1'b0;
      cycle_limit <= 1'b0;
      sr_drive_e <= 1'b0;
      sr_drive_f <= 1'b0;
    end else begin
      switching_en <= run_ok;
      cycle_limit <= run_ok && cs_at_limit;
      sr_drive_e <= run_ok && !dcm_mode && !out_phase;
      sr_drive_f <= run_ok && !dcm_mode && out_phase;
    end
  end

  // pulldown held to the start of the next cycle; a trip on that edge wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_pulldown_en <= 1'b0;
    end else if (pwm_trip) begin
      cs_pulldown_en <= 1'b1;
    end else if (osc_start) begin
      cs_pulldown_en <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_dcm_drives_off: assert property (dcm_mode |=> (!sr_drive_e && !sr_drive_f))
    else $error("rectifier drive active in light-load mode");
  chk_tied_ref_dcm: assert property (llt_tied_ref |=> dcm_mode)
    else $error("tied threshold did not force light-load mode");
  chk_grounded_ccm: assert property ((llt_grounded && !llt_tied_ref) |=> !dcm_mode)
    else $error("grounded threshold did not force continuous mode");
  chk_mode_qualify: assert property (($changed(dcm_mode) && !$past(llt_tied_ref) &&
      !$past(llt_grounded)) |-> ($past(pwm_fall) && $past(qual) == 2'h1))
    else $error("mode changed without two qualifying pwm edges");
  chk_pulldown_trip: assert property (pwm_trip |=> cs_pulldown_en)
    else $error("sense pulldown not enabled after trip");
  chk_ramp_charging: assert property ((state == SS_RAMP && cs_at_limit && !ss_hold &&
      ss_cnt < ramp_cfg - 24'h000001) |=> (state == SS_RAMP && cycle_limit == $past(run_ok)))
    else $error("early overcurrent left the ramp");
  chk_hiccup_off: assert property ((state == SS_HICCUP) |=> !switching_en)
    else $error("switching during hiccup off-time");
  chk_latch_hold: assert property ((state == SS_LATCH && !ss_hold) |=>
      (state == SS_LATCH))
    else $error("latch-off released without discharge");
  chk_latch_clear: assert property (ss_hold |=> (state == SS_LOW))
    else $error("forced discharge did not reset the soft-start");
  chk_follower_quiet: assert property (!leader |=> !sync_oe)
    else $error("follower drives the sync line");
  chk_sync_align: assert property (sync_fall |=>
      (osc_cnt == 16'h0000 && $changed(out_phase)))
    else $error("follower clock not aligned to sync edge");
  chk_follower_wait: assert property ((!leader && !sync_seen) |=> !switching_en)
    else $error("follower switching before first sync pulse");
  chk_leader_gate: assert property ((state == SS_LOW) |=> !sync_out)
    else $error("sync pulses before soft-start enable");
  chk_limit_follow: assert property ((run_ok && cs_at_limit) |=> cycle_limit)
    else $error("current limit not applied");
  chk_limit_release: assert property (!cs_at_limit |=> !cycle_limit)
    else $error("cycle limit held without a limit event");
  chk_ccm_drives_on: assert property ((run_ok && !dcm_mode) |=> (sr_drive_e != sr_drive_f))
    else $error("rectifier drives not alternating in continuous mode");
  chk_limit_timing: assert property ((state == SS_RAMP && !ss_hold && !latch_en &&
      ss_cnt >= ramp_cfg - 24'h000001 && (cs_at_limit || cl_seen)) |=> (state == SS_CLTIME))
    else $error("limit timing did not start at the ramp threshold");
  chk_hiccup_restart: assert property ((state == SS_HICCUP && !ss_hold &&
      ss_cnt >= off_cfg - 24'h000001) |=> (state == SS_LOW))
    else $error("hiccup off-time did not end in a restart");
  chk_leader_oe: assert property (leader |=> sync_oe)
    else $error("leader not driving the sync line");
  chk_sync_low_half: assert property ((leader && osc_cnt >= (osc_period >> 1)) |=> !sync_out)
    else $error("sync pulse high in the second half of the period");
  chk_follower_silent: assert property (!leader |=> !sync_out)
    else $error("follower produced a sync pulse");
  chk_osc_free_run: assert property (!osc_start |=> (osc_cnt == $past(osc_cnt) + 16'h0001))
    else $error("oscillator stalled without a restart");
  chk_follower_ramp: assert property ((!leader && !sync_seen && state == SS_LOW && !ss_hold) |=>
      (state == SS_RAMP))
    else $error("follower soft-start waited for sync");
  chk_pulldown_hold: assert property ((cs_pulldown_en && !osc_start) |=> cs_pulldown_en)
    else $error("sense pulldown released before the next cycle");

endmodule

// ### tb/sync_peer_model.sv
// peer leader controller driving the shared sync line toward the block
`timescale 1ns/1ps
module sync_peer_model #(
  parameter int PERIOD = 16
) (
  input wire logic pclk,
  input wire logic run,
  output logic sync_line
);
  int cnt;
  // half-duty pulses at the oscillator rate, above the 1.8x floor
  always_ff @(posedge pclk) begin
    if (!run) begin
      // stopped: the line rests at the pull-down level
      cnt <= 0;
      sync_line <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      sync_line <= (cnt < PERIOD / 2);
    end
  end
endmodule

// ### tb/tb.sv
// self-checking bench for the light-load, hiccup and sync supervisor
`timescale 1ns/1ps
module tb;
  import hiccup_sync_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, sr_e, sr_f, light_load_threshold_input, hyst, pdn, clim, sw, ph, s_out, s_oe;
  logic below = 0, tied = 0, gnd = 0, lim = 0, trip = 0, fall = 0, uvlo = 0, forced = 0;
  logic sync_in, pp, peer_run = 0;
  int failures = 0, cmp_count = 0, cycles = 0, n;
  always #12.5 pclk = ~pclk;
  light_load_hiccup_sync_control #(.OSC_PERIOD(16), .RAMP_CYCLES(50), .CL_ON_CYCLES(40),
    .OFF_CYCLES(60)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cs_below_llt(below), .llt_tied_ref(tied), .llt_grounded(gnd),
    .cs_at_limit(lim), .pwm_trip(trip), .pwm_fall(fall), .uvlo(uvlo), .ss_forced_low(forced),
    .sync_in(sync_in), .sr_drive_e(sr_e), .sr_drive_f(sr_f), .dcm_mode(light_load_threshold_input),
    .hyst_src_en(hyst), .cs_pulldown_en(pdn), .cycle_limit(clim), .switching_en(sw),
    .out_phase(ph), .sync_out(s_out), .sync_oe(s_oe));
  sync_peer_model #(.PERIOD(16)) peer (.pclk(pclk), .run(peer_run), .sync_line(sync_in));
  task conclude;
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // a run that stalls is cut short and judged as failed
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      conclude();
    end
  end
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task wt(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task state_is(input logic [2:0] s);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("state", {29'h0, s}, {29'h0, rd[2:0]});
  endtask
  task pwm_falls(input int k);
    repeat (k) begin
      fall <= 1'b1;
      @(posedge pclk);
      fall <= 1'b0;
      wt(2);
    end
  endtask
  initial begin
    logic [APB_AW-1:0] ofs [5] = '{CTRL_OFS, OSC_OFS, RAMP_OFS, CLON_OFS, OFF_OFS};
    logic [31:0] rv [5] = '{32'h1, 32'h10, 32'h32, 32'h28, 32'h3C};
    wt(12);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk("reset value", rv[i], rd);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, STAT_OFS, 32'hFFFFFFFF);
    chk("status write err", 32'h0, {31'h0, err});
    wt(30);
    state_is(3'h2);
    chk("switching", 32'h1, {31'h0, sw});
    n = 0;
    repeat (16) begin
      @(posedge pclk);
      n += int'(s_out);
    end
    chk("sync high count", 32'd8, n);
    chk("sync oe", 32'h1, {31'h0, s_oe});
    below <= 1'b1;
    pwm_falls(1);
    chk("dcm one fall", 32'h0, {31'h0, light_load_threshold_input});
    pwm_falls(1);
    chk("dcm two falls", 32'h1, {31'h0, light_load_threshold_input});
    chk("hysteresis on", 32'h1, {31'h0, hyst});
    chk("drives off", 32'h0, {30'h0, sr_e, sr_f});
    below <= 1'b0;
    pwm_falls(2);
    chk("ccm", 32'h0, {31'h0, light_load_threshold_input});
    chk("hysteresis off", 32'h0, {31'h0, hyst});
    chk("drive active", 32'h1, {31'h0, sr_e | sr_f});
    tied <= 1'b1;
    wt(3);
    chk("tied dcm", 32'h1, {31'h0, light_load_threshold_input});
    tied <= 1'b0;
    gnd <= 1'b1;
    below <= 1'b1;
    pwm_falls(2);
    chk("grounded ccm", 32'h0, {31'h0, light_load_threshold_input});
    gnd <= 1'b0;
    below <= 1'b0;
    trip <= 1'b1;
    @(posedge pclk);
    trip <= 1'b0;
    #1;
    chk("pulldown on", 32'h1, {31'h0, pdn});
    wt(20);
    chk("pulldown cleared", 32'h0, {31'h0, pdn});
    lim <= 1'b1;
    wt(2);
    chk("cycle limit", 32'h1, {31'h0, clim});
    state_is(3'h3);
    wt(45);
    state_is(3'h4);
    chk("hiccup stop", 32'h0, {31'h0, sw});
    apb(1'b1, CTRL_OFS, 32'h3);
    wt(48);
    state_is(3'h1);
    chk("ramp limit", 32'h1, {31'h0, clim});
    wt(60);
    state_is(3'h5);
    lim <= 1'b0;
    wt(30);
    state_is(3'h5);
    chk("latched stop", 32'h0, {31'h0, sw});
    forced <= 1'b1;
    wt(3);
    state_is(3'h0);
    n = 0;
    repeat (20) begin
      @(posedge pclk);
      n += int'(s_out);
    end
    chk("sync before enable", 32'h0, n);
    forced <= 1'b0;
    wt(5);
    state_is(3'h1);
    apb(1'b1, CTRL_OFS, 32'h0);
    uvlo <= 1'b1;
    wt(3);
    uvlo <= 1'b0;
    wt(70);
    state_is(3'h2);
    chk("follower waits", 32'h0, {31'h0, sw});
    chk("follower oe", 32'h0, {31'h0, s_oe});
    peer_run <= 1'b1;
    wt(40);
    chk("follower runs", 32'h1, {31'h0, sw});
    apb(1'b0, STAT_OFS, 32'h0);
    chk("sync seen", 32'h1, {31'h0, rd[7]});
    peer_run <= 1'b0;
    wt(60);
    pp = ph;
    n = 0;
    repeat (32) begin
      @(posedge pclk);
      n += int'(ph != pp);
      pp = ph;
    end
    chk("free running toggles", 32'd2, n);
    chk("free running", 32'h1, {31'h0, sw});
    conclude();
  end
endmodule
